// ===== cce_pkg.sv
// constants and types for the codec clock enable control block
package cce_pkg;
  localparam logic [7:0] CLOCK_ENABLE_CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] CLOCK_ENABLE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PLL_CONFIG_FIRST_OFFSET = 8'h01;
  localparam logic [7:0] PLL_LOCK_REGISTER_OFFSET = 8'h06;
  localparam int PLL_ENABLE_POS = 7;
  localparam int GLITCH_FILTER_DISABLE_POS = 5;
  localparam int OSCILLATOR_DISABLE_POS = 4;
  localparam int MAIN_CLOCK_SELECT_POS = 3;
  localparam int CORE_CLOCK_HALVE_SELECT_POS = 2;
  localparam int MASTER_CLOCK_HALVE_SELECT_POS = 1;
  localparam int MAIN_CLOCK_ENABLE_POS = 0;
  localparam int SYS_CLK_KHZ = 10000;
  localparam int GLITCH_FILTER_NS = 50;
  localparam int GLITCH_FILTER_RAW = (GLITCH_FILTER_NS * SYS_CLK_KHZ + 999999) / 1000000;
  localparam int GLITCH_FILTER_CYCLES = (GLITCH_FILTER_RAW < 1) ? 1 : GLITCH_FILTER_RAW;

  typedef struct packed {
    logic pllEnable;
    logic reserved6;
    logic glitchFilterDisable;
    logic oscillatorDisable;
    logic mainClockSelect;
    logic coreClockHalveSelect;
    logic masterClockHalveSelect;
    logic mainClockEnable;
  } cce_ctrl_type;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } cce_write_type;
endpackage

// ===== cce_glitch_filter.sv
// spike filter for one synchronised control-port input
`timescale 1ns/1ps
module cce_glitch_filter #(
  parameter int FILT_CYC = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // filter path
  input wire logic syncIn,
  input wire logic bypass,
  output logic filtOut
);
  localparam int CW = $clog2(FILT_CYC + 1) + 1;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic out_ff;
  logic nxt_out;

  always_comb
  begin
    nxt_cnt = '0;
    nxt_out = out_ff;
    if (bypass)
    begin
      nxt_out = syncIn;
    end
    else if (syncIn != out_ff)
    begin
      // a level must persist past the filter time before it is taken
      if (cnt_ff >= CW'(FILT_CYC))
      begin
        nxt_out = syncIn;
      end
      else
      begin
        nxt_cnt = cnt_ff + CW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_ff <= '0;
      out_ff <= 1'b1;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
    end
  end

  assign filtOut = out_ff;
endmodule

// ===== cce_clock_control.sv
// clock enable control register with clock gating, dividers and spike filter
// Summary of operation
// - PLL enable bit 7 clear keeps PLL powered down and its clock off.
// - PLL clock output active only when PLL enable and main enable set.
// - Main enable bit 0 clear: only clock and PLL registers accept writes.
// - Control-port inputs get a 50 ns spike filter; bit 5 bypasses it.
// - SPI mode disables the spike filter regardless of bit 5.
// - Bit 3 selects main clock: 0 external pin, 1 PLL output.
// - Bit 2: core clock is source/2 when 0, source/1 when 1.
// - Bit 1: master clock is source/2 when 0, source/1 when 1.
// - Register resets to zero: PLL, main clock, divide-by-one off, pin source.
`timescale 1ns/1ps
module cce_clock_control #(
  parameter int FILT_CYC = cce_pkg::GLITCH_FILTER_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // register port from the control interface
  input wire logic regWrEn,
  input wire logic [7:0] regWrAddr,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  input wire logic [7:0] regRdAddr,
  output logic [7:0] regRdData,
  output logic regRdValid,
  // writes passed on to the other registers
  output logic fwdWrValid,
  output logic [7:0] fwdWrAddr,
  output logic [7:0] fwdWrData,
  // clock controls
  output logic pllPowerUp,
  output logic pllClockEnable,
  output logic oscillatorEnable,
  output logic mainSelectPll,
  output logic mainClockOn,
  // source clock ticks and derived ticks
  input wire logic srcTick,
  output logic coreTick,
  output logic masterTick,
  // control port pins
  input wire logic spiMode,
  input wire logic sclPin,
  input wire logic sdaPin,
  output logic sclFiltered,
  output logic sdaFiltered
);
  cce_pkg::cce_ctrl_type ctrl_ff;
  cce_pkg::cce_ctrl_type nxt_ctrl;
  cce_pkg::cce_write_type fwd_ff;
  cce_pkg::cce_write_type nxt_fwd;
  logic [7:0] rdData_ff;
  logic [7:0] nxt_rdData;
  logic rdValid_ff;
  logic nxt_rdValid;
  logic pllPowerUp_ff;
  logic pllClockEnable_ff;
  logic oscEnable_ff;
  logic mainSelPll_ff;
  logic mainOn_ff;
  logic coreTick_ff;
  logic masterTick_ff;
  logic corePhase_ff;
  logic masterPhase_ff;
  logic nxt_coreTick;
  logic nxt_masterTick;
  logic nxt_corePhase;
  logic nxt_masterPhase;
  logic [2:0] pinMeta_ff;
  logic [2:0] pinSync_ff;
  logic filterBypass;
  logic sclSync;
  logic sdaSync;
  logic spiSync;
  logic pllRegAddr;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, two flops before any logic reads them
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      // spi sync resets low so the filter is armed from the first cycle
      pinMeta_ff <= 3'h3;
      pinSync_ff <= 3'h3;
    end
    else
    begin
      pinMeta_ff <= {spiMode, sdaPin, sclPin};
      pinSync_ff <= pinMeta_ff;
    end
  end

  assign sclSync = pinSync_ff[0];
  assign sdaSync = pinSync_ff[1];
  assign spiSync = pinSync_ff[2];
  assign filterBypass = ctrl_ff.glitchFilterDisable | spiSync;

  //////////////////////////////////////////////////////////////////////////////
  // register writes, reads and forwarding
  assign pllRegAddr = (regWrAddr >= cce_pkg::PLL_CONFIG_FIRST_OFFSET) &&
                      (regWrAddr <= cce_pkg::PLL_LOCK_REGISTER_OFFSET);

  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_fwd = '0;
    nxt_rdValid = regRdEn;
    nxt_rdData = 8'h00;
    if (regWrEn && regWrAddr == cce_pkg::CLOCK_ENABLE_CONTROL_OFFSET)
    begin
      nxt_ctrl = cce_pkg::cce_ctrl_type'(regWrData);
    end
    // writes outside the PLL registers are dropped silently until the main clock runs
    else if (regWrEn && (pllRegAddr || ctrl_ff.mainClockEnable))
    begin
      nxt_fwd.valid = 1'b1;
      nxt_fwd.addr = regWrAddr;
      nxt_fwd.data = regWrData;
    end
    // other registers answer reads elsewhere, so this block returns zero there
    if (regRdEn && regRdAddr == cce_pkg::CLOCK_ENABLE_CONTROL_OFFSET)
    begin
      nxt_rdData = ctrl_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_ff <= cce_pkg::cce_ctrl_type'(cce_pkg::CLOCK_ENABLE_CONTROL_RESET);
      fwd_ff <= '0;
      rdValid_ff <= 1'b0;
      rdData_ff <= 8'h00;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      fwd_ff <= nxt_fwd;
      rdValid_ff <= nxt_rdValid;
      rdData_ff <= nxt_rdData;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // clock controls follow the register in the same cycle it updates
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pllPowerUp_ff <= 1'b0;
      pllClockEnable_ff <= 1'b0;
      oscEnable_ff <= ~cce_pkg::CLOCK_ENABLE_CONTROL_RESET[cce_pkg::OSCILLATOR_DISABLE_POS];
      mainSelPll_ff <= 1'b0;
      mainOn_ff <= 1'b0;
    end
    else
    begin
      pllPowerUp_ff <= nxt_ctrl.pllEnable;
      pllClockEnable_ff <= nxt_ctrl.pllEnable & nxt_ctrl.mainClockEnable;
      oscEnable_ff <= ~nxt_ctrl.oscillatorDisable;
      mainSelPll_ff <= nxt_ctrl.mainClockSelect;
      mainOn_ff <= nxt_ctrl.mainClockEnable;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // core and master tick dividers on the selected source
  always_comb
  begin
    nxt_corePhase = corePhase_ff;
    nxt_masterPhase = masterPhase_ff;
    nxt_coreTick = 1'b0;
    nxt_masterTick = 1'b0;
    if (srcTick && mainOn_ff)
    begin
      nxt_corePhase = ~corePhase_ff;
      nxt_masterPhase = ~masterPhase_ff;
      nxt_coreTick = ctrl_ff.coreClockHalveSelect | corePhase_ff;
      nxt_masterTick = ctrl_ff.masterClockHalveSelect | masterPhase_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      corePhase_ff <= 1'b0;
      masterPhase_ff <= 1'b0;
      coreTick_ff <= 1'b0;
      masterTick_ff <= 1'b0;
    end
    else
    begin
      corePhase_ff <= nxt_corePhase;
      masterPhase_ff <= nxt_masterPhase;
      coreTick_ff <= nxt_coreTick;
      masterTick_ff <= nxt_masterTick;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // spike filters
  cce_glitch_filter #(.FILT_CYC(FILT_CYC)) sclFilter (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .syncIn(sclSync),
    .bypass(filterBypass),
    .filtOut(sclFiltered)
  );

  cce_glitch_filter #(.FILT_CYC(FILT_CYC)) sdaFilter (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .syncIn(sdaSync),
    .bypass(filterBypass),
    .filtOut(sdaFiltered)
  );

  assign regRdData = rdData_ff;
  assign regRdValid = rdValid_ff;
  assign fwdWrValid = fwd_ff.valid;
  assign fwdWrAddr = fwd_ff.addr;
  assign fwdWrData = fwd_ff.data;
  assign pllPowerUp = pllPowerUp_ff;
  assign pllClockEnable = pllClockEnable_ff;
  assign oscillatorEnable = oscEnable_ff;
  assign mainSelectPll = mainSelPll_ff;
  assign mainClockOn = mainOn_ff;
  assign coreTick = coreTick_ff;
  assign masterTick = masterTick_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  logic firstCyc_ff;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      firstCyc_ff <= 1'b1;
    else
      firstCyc_ff <= 1'b0;
  end

  property p_pll_off;
    @(posedge sys_clk) disable iff (!rstn)
    !ctrl_ff.pllEnable |-> !pllPowerUp_ff && !pllClockEnable_ff;
  endproperty
  a_pll_off: assert property (p_pll_off) else $error("pll active while disabled");

  property p_pll_clock_both;
    @(posedge sys_clk) disable iff (!rstn)
    pllClockEnable_ff == (ctrl_ff.pllEnable && ctrl_ff.mainClockEnable);
  endproperty
  a_pll_clock_both: assert property (p_pll_clock_both) else $error("pll clock gating wrong");

  property p_write_block;
    @(posedge sys_clk) disable iff (!rstn)
    regWrEn && !ctrl_ff.mainClockEnable && regWrAddr > 8'h06 |=> !fwdWrValid;
  endproperty
  a_write_block: assert property (p_write_block) else $error("write passed while main clock off");

  property p_pll_write_pass;
    @(posedge sys_clk) disable iff (!rstn)
    regWrEn && regWrAddr >= 8'h01 && regWrAddr <= 8'h06 |=> fwdWrValid && fwdWrAddr == $past(regWrAddr);
  endproperty
  a_pll_write_pass: assert property (p_pll_write_pass) else $error("pll write not passed");

  property p_spike_reject;
    @(posedge sys_clk) disable iff (!rstn)
    !filterBypass && sclSync != sclFiltered && $past(sclSync) == $past(sclFiltered) |=> $stable(sclFiltered);
  endproperty
  a_spike_reject: assert property (p_spike_reject) else $error("spike passed filter");

  property p_bypass;
    @(posedge sys_clk) disable iff (!rstn)
    spiSync |=> sdaFiltered == $past(sdaSync);
  endproperty
  a_bypass: assert property (p_bypass) else $error("filter not bypassed in spi mode");

  property p_osc;
    @(posedge sys_clk) disable iff (!rstn)
    oscEnable_ff != ctrl_ff.oscillatorDisable;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator control wrong");

  property p_select;
    @(posedge sys_clk) disable iff (!rstn)
    regWrEn && regWrAddr == 8'h00 |=> mainSelectPll == $past(regWrData[3]);
  endproperty
  a_select: assert property (p_select) else $error("main select wrong");

  property p_core_half;
    @(posedge sys_clk) disable iff (!rstn)
    coreTick_ff && !ctrl_ff.coreClockHalveSelect && !$past(ctrl_ff.coreClockHalveSelect) &&
      !$past(ctrl_ff.coreClockHalveSelect, 2) |-> !$past(coreTick_ff);
  endproperty
  a_core_half: assert property (p_core_half) else $error("core tick not halved");

  property p_master_full;
    @(posedge sys_clk) disable iff (!rstn)
    srcTick && mainOn_ff && ctrl_ff.masterClockHalveSelect |=> masterTick_ff;
  endproperty
  a_master_full: assert property (p_master_full) else $error("master tick missing");

  property p_reset_zero;
    @(posedge sys_clk) disable iff (!rstn)
    firstCyc_ff |-> ctrl_ff == 8'h00 && !mainSelPll_ff;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("register not zero after reset");

  c_pll_on: cover property (@(posedge sys_clk) disable iff (!rstn) pllClockEnable_ff);
  c_spi_bypass: cover property (@(posedge sys_clk) disable iff (!rstn) spiSync && $changed(sclFiltered));
  c_blocked: cover property (@(posedge sys_clk) disable iff (!rstn) regWrEn && !ctrl_ff.mainClockEnable && !pllRegAddr);
endmodule

// ===== test_codec_clock_enable_control.sv
// self-checking testbench for the clock enable control register
`timescale 1ns/1ps
module test_codec_clock_enable_control;
  logic sys_clk, rstn, regWrEn, regRdEn, srcTick, spiMode, sclPin, sdaPin;
  logic [7:0] regWrAddr, regWrData, regRdAddr, regRdData, fwdWrAddr, fwdWrData;
  logic regRdValid, fwdWrValid, pllPowerUp, pllClockEnable, oscillatorEnable, mainSelectPll, mainClockOn;
  logic coreTick, masterTick, sclFiltered, sdaFiltered;
  logic [15:0] rs = 16'h7c0a;
  logic [7:0] rdQ[$];
  logic [15:0] fwdQ[$];
  int fails = 0;
  int cmp_count = 0;
  int coreCnt = 0;
  int masterCnt = 0;
  int lowCnt = 0;

  cce_clock_control dut (
    .sys_clk(sys_clk), .rstn(rstn),
    .regWrEn(regWrEn), .regWrAddr(regWrAddr), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdAddr(regRdAddr), .regRdData(regRdData), .regRdValid(regRdValid),
    .fwdWrValid(fwdWrValid), .fwdWrAddr(fwdWrAddr), .fwdWrData(fwdWrData),
    .pllPowerUp(pllPowerUp), .pllClockEnable(pllClockEnable), .oscillatorEnable(oscillatorEnable),
    .mainSelectPll(mainSelectPll), .mainClockOn(mainClockOn),
    .srcTick(srcTick), .coreTick(coreTick), .masterTick(masterTick),
    .spiMode(spiMode), .sclPin(sclPin), .sdaPin(sdaPin),
    .sclFiltered(sclFiltered), .sdaFiltered(sdaFiltered)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] xs();
    rs ^= rs << 7;
    rs ^= rs >> 9;
    rs ^= rs << 8;
    return rs;
  endfunction

  function automatic logic [15:0] ctrlV();
    return {11'h000, pllPowerUp, pllClockEnable, oscillatorEnable, mainSelectPll, mainClockOn};
  endfunction

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (rdQ.size() != 0 || fwdQ.size() != 0)
      chk("pending answers", 16'h0001, 16'h0000);
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // bus drivers note the expected answer before the request
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit fwd);
    if (fwd)
      fwdQ.push_back({a, d});
    @(negedge sys_clk);
    regWrEn = 1'b1;
    regWrAddr = a;
    regWrData = d;
    @(negedge sys_clk);
    regWrEn = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rdQ.push_back(exp);
    @(negedge sys_clk);
    regRdEn = 1'b1;
    regRdAddr = a;
    @(negedge sys_clk);
    regRdEn = 1'b0;
  endtask

  // ticks spaced by a cycle; even counts keep the halving phase aligned
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(negedge sys_clk);
      srcTick = 1'b1;
      @(negedge sys_clk);
      srcTick = 1'b0;
    end
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic glitch(input int len, output int seen);
    logic [15:0] r;
    int l0;
    r = xs();
    l0 = lowCnt;
    @(negedge sys_clk);
    if (r[0])
      sdaPin = 1'b0;
    else
      sclPin = 1'b0;
    repeat (len) @(negedge sys_clk);
    sdaPin = 1'b1;
    sclPin = 1'b1;
    repeat (8) @(negedge sys_clk);
    seen = lowCnt - l0;
  endtask

  task automatic endtest(input string name);
    $display("test %s done", name);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge sys_clk)
  begin
    if (rstn === 1'b1)
    begin
      if (regRdValid === 1'b1)
      begin
        if (rdQ.size() == 0)
          chk("unexpected read", 16'h0001, 16'h0000);
        else
          chk("read data", {8'h00, regRdData}, {8'h00, rdQ.pop_front()});
      end
      if (fwdWrValid === 1'b1)
      begin
        if (fwdQ.size() == 0)
          chk("unexpected forward", {fwdWrAddr, fwdWrData}, 16'h0000);
        else
          chk("forward", {fwdWrAddr, fwdWrData}, fwdQ.pop_front());
      end
      if (coreTick === 1'b1)
        coreCnt++;
      if (masterTick === 1'b1)
        masterCnt++;
      if (sclFiltered !== 1'b1 || sdaFiltered !== 1'b1)
        lowCnt++;
    end
  end

  // whole sequence is well under 2000 cycles
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    $display("ERROR watchdog expected done seen timeout");
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [15:0] r;
    cce_pkg::cce_ctrl_type c;
    int c0, m0, g;
    {rstn, regWrEn, regRdEn, srcTick, spiMode} = 5'h00;
    {regWrAddr, regWrData, regRdAddr} = 24'h000000;
    sclPin = 1'b1;
    sdaPin = 1'b1;
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    @(negedge sys_clk);
    chk("ctrl after reset", ctrlV(), 16'h0004);
    chk("filtered idle", {14'h0000, sclFiltered, sdaFiltered}, 16'h0003);
    rd(8'h00, 8'h00);
    endtest("reset");
    wr(8'h10, 8'h55, 1'b0);
    wr(8'h03, 8'h5a, 1'b1);
    wr(8'h00, 8'h80, 1'b0);
    chk("pll on main off", ctrlV(), 16'h0014);
    wr(8'h00, 8'h81, 1'b0);
    chk("pll and main on", ctrlV(), 16'h001d);
    // lock flag lives outside this block; pll running stands in for it
    wr(8'h00, 8'h89, 1'b0);
    chk("pll selected", ctrlV(), 16'h001f);
    wr(8'h10, 8'h55, 1'b1);
    wr(8'h00, 8'h01, 1'b0);
    chk("pll off", ctrlV(), 16'h0005);
    endtest("gating");
    repeat (12)
    begin
      r = xs();
      r[3] = r[3] & r[7] & r[0];
      c = r[7:0];
      wr(8'h00, r[7:0], 1'b0);
      chk("ctrl random", ctrlV(), {11'h000, c.pllEnable, c.pllEnable & c.mainClockEnable,
        ~c.oscillatorDisable, c.mainClockSelect, c.mainClockEnable});
      rd(8'h00, r[7:0]);
    end
    rd(8'h05, 8'h00);
    endtest("random");
    // source rate is abstract here, so every divider pairing is tried
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h00, {5'h00, m[1:0], 1'b1}, 1'b0);
      c0 = coreCnt;
      m0 = masterCnt;
      ticks(6);
      chk("core ticks", 16'(coreCnt - c0), m[1] ? 16'h0006 : 16'h0003);
      chk("master ticks", 16'(masterCnt - m0), m[0] ? 16'h0006 : 16'h0003);
    end
    wr(8'h00, 8'h06, 1'b0);
    c0 = coreCnt;
    m0 = masterCnt;
    ticks(6);
    chk("ticks main off", 16'(coreCnt - c0 + masterCnt - m0), 16'h0000);
    endtest("dividers");
    wr(8'h00, 8'h00, 1'b0);
    glitch(1, g);
    chk("spike blocked", 16'(g != 0), 16'h0000);
    glitch(4, g);
    chk("long pulse", 16'(g != 0), 16'h0001);
    wr(8'h00, 8'h20, 1'b0);
    glitch(1, g);
    chk("spike bypass", 16'(g != 0), 16'h0001);
    wr(8'h00, 8'h00, 1'b0);
    spiMode = 1'b1;
    repeat (4) @(negedge sys_clk);
    glitch(1, g);
    chk("spike spi", 16'(g != 0), 16'h0001);
    spiMode = 1'b0;
    endtest("filter");
    repeat (4) @(negedge sys_clk);
    finish_test();
  end
endmodule
